// File: logic/wdu_top.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "wdu_defs.svh"
module wdu_top import wdu_pkg::*; (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  // configuration options
  input wire logic cfg_core_div_src,
  input wire logic cfg_wdt_enable,
  input wire logic cfg_paired_kick,
  // core clocking and power state
  input wire logic core_tick,
  input wire logic low_rate_tick,
  input wire logic core_halted,
  input wire logic core_low_power,
  input wire logic external_init_n,
  // wake-up context
  input wire logic wake_event,
  input wire logic deep_stop_keep_low_clock,
  input wire logic crystal_osc,
  input wire logic fast_wake_enable,
  // outputs to the device
  output logic device_reset_r,
  output logic pc_sp_clear_r,
  output logic idle_core_clock_keep_r,
  output logic low_rate_clock_on_r,
  output logic wake_on_low_speed_osc_r,
  output logic irq_r
);

  // register state
  wdu_ctrl_t watchdog_control_r;
  wdu_ctrl_t watchdog_control_nxt;
  logic expiry_flag_r;
  logic expiry_flag_nxt;
  logic power_down_flag_r;
  logic power_down_flag_nxt;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_stat_nxt;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_mask_nxt;
  wdu_half_e half_r;
  wdu_half_e half_nxt;

  // bus state
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;

  // output state
  logic device_reset_nxt;
  logic pc_sp_clear_nxt;
  logic idle_keep_nxt;
  logic low_rate_on_nxt;
  logic wake_low_nxt;
  logic irq_nxt;

  // internal signals
  logic acc_w;
  logic wr_w;
  logic mapped_w;
  logic enabled_w;
  logic op_single;
  logic first_half_kick;
  logic second_half_kick;
  logic op_stop;
  logic kick_valid;
  logic cnt_clear;
  logic wd_tick;
  logic ovf;
  wdu_count_t count;

  function automatic logic wdu_mapped(input logic [7:0] a);
    return a == `WDU_OFS_CTRL || a == `WDU_OFS_FLAGS || a == `WDU_OFS_IRQ_STAT ||
           a == `WDU_OFS_IRQ_MASK || a == `WDU_OFS_OPS || a == `WDU_OFS_COUNT;
  endfunction

  function automatic logic op_bit(input logic w, input logic [7:0] a,
                                  input logic [31:0] d, input int b);
    return w && a == `WDU_OFS_OPS && d[b];
  endfunction

  // bus decode: access completes when pready is seen high
  assign acc_w = psel && penable && pready_r;
  assign wr_w = acc_w && pwrite && mapped_w;
  assign mapped_w = wdu_mapped(paddr);

  assign enabled_w = wdu_enabled(cfg_wdt_enable,
    watchdog_control_r[`WDU_KEY_HI:`WDU_KEY_LO]);

  // watchdog operations arrive as strobes in the operation register
  assign op_single = op_bit(wr_w, paddr, pwdata, `WDU_OP_SINGLE);
  assign first_half_kick = op_bit(wr_w, paddr, pwdata, `WDU_OP_FIRST);
  assign second_half_kick = op_bit(wr_w, paddr, pwdata, `WDU_OP_SECOND);
  assign op_stop = op_bit(wr_w, paddr, pwdata, `WDU_OP_STOP);

  // both halves in one write are ambiguous and ignored
  always_comb begin
    kick_valid = 1'b0;
    if (enabled_w) begin
      if (cfg_paired_kick) begin
        kick_valid = (first_half_kick && !second_half_kick && half_r != WDU_HALF_FIRST) ||
                     (second_half_kick && !first_half_kick && half_r != WDU_HALF_SECOND);
      end else begin
        kick_valid = op_single;
      end
    end
  end

  // disabled timer is held cleared so it restarts from zero
  assign cnt_clear = !external_init_n || kick_valid || op_stop || !enabled_w;

  wdu_tick_gen i_wdu_tick_gen (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .core_tick(core_tick),
    .low_rate_tick(low_rate_tick),
    .sel_core(cfg_core_div_src),
    .core_halted(core_halted),
    .run(enabled_w),
    .wd_tick(wd_tick)
  );

  wdu_stage_counter i_wdu_stage_counter (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(wd_tick),
    .clear(cnt_clear),
    .sel(watchdog_control_r[`WDU_PSEL_HI:`WDU_PSEL_LO]),
    .count(count),
    .overflow(ovf)
  );

  // control, flags, interrupt and kick history
  always_comb begin
    watchdog_control_nxt = watchdog_control_r;
    expiry_flag_nxt = expiry_flag_r;
    power_down_flag_nxt = power_down_flag_r;
    irq_stat_nxt = irq_stat_r;
    irq_mask_nxt = irq_mask_r;
    half_nxt = half_r;
    if (wr_w && paddr == `WDU_OFS_CTRL) begin
      watchdog_control_nxt = pwdata[7:0];
    end
    if (wr_w && paddr == `WDU_OFS_IRQ_MASK) begin
      irq_mask_nxt = pwdata[1:0];
    end
    if (wr_w && paddr == `WDU_OFS_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~pwdata[1:0];
    end
    if (ovf) begin
      irq_stat_nxt[`WDU_IRQ_OVF] = 1'b1;
    end
    if (op_stop) begin
      irq_stat_nxt[`WDU_IRQ_STOP] = 1'b1;
    end
    if (kick_valid && cfg_paired_kick) begin
      half_nxt = first_half_kick ? WDU_HALF_FIRST : WDU_HALF_SECOND;
    end
    if (kick_valid) begin
      power_down_flag_nxt = 1'b0;
    end
    if (op_stop) begin
      power_down_flag_nxt = 1'b1;
      expiry_flag_nxt = 1'b0;
    end
    if (ovf) begin
      expiry_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_control_r <= `WDU_CTRL_RESET;
      expiry_flag_r <= 1'b0;
      power_down_flag_r <= 1'b0;
      irq_stat_r <= `WDU_IRQ_RESET;
      irq_mask_r <= `WDU_IRQ_RESET;
      half_r <= WDU_HALF_NONE;
    end else if (ce) begin
      watchdog_control_r <= watchdog_control_nxt;
      expiry_flag_r <= expiry_flag_nxt;
      power_down_flag_r <= power_down_flag_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      half_r <= half_nxt;
    end
  end

  // apb answer: one wait state, read data ready with pready
  always_comb begin
    pready_nxt = psel && penable && !pready_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel && penable && !pready_r) begin
      pslverr_nxt = !mapped_w;
      prdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `WDU_OFS_CTRL: prdata_nxt = {24'h00_0000, watchdog_control_r};
          `WDU_OFS_FLAGS: prdata_nxt = {30'h0000_0000, power_down_flag_r, expiry_flag_r};
          `WDU_OFS_IRQ_STAT: prdata_nxt = {30'h0000_0000, irq_stat_r};
          `WDU_OFS_IRQ_MASK: prdata_nxt = {30'h0000_0000, irq_mask_r};
          `WDU_OFS_COUNT: prdata_nxt = {17'h0_0000, count};
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // device-facing outputs
  always_comb begin
    device_reset_nxt = ovf && !core_low_power;
    pc_sp_clear_nxt = ovf && core_low_power;
    idle_keep_nxt = watchdog_control_nxt[`WDU_IDLE_KEEP_BIT];
    low_rate_on_nxt = enabled_w;
    wake_low_nxt = wake_on_low_speed_osc_r;
    if (wake_event) begin
      wake_low_nxt = deep_stop_keep_low_clock && crystal_osc && fast_wake_enable;
    end
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset_r <= 1'b0;
      pc_sp_clear_r <= 1'b0;
      idle_core_clock_keep_r <= 1'b0;
      low_rate_clock_on_r <= 1'b0;
      wake_on_low_speed_osc_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce) begin
      device_reset_r <= device_reset_nxt;
      pc_sp_clear_r <= pc_sp_clear_nxt;
      idle_core_clock_keep_r <= idle_keep_nxt;
      low_rate_clock_on_r <= low_rate_on_nxt;
      wake_on_low_speed_osc_r <= wake_low_nxt;
      irq_r <= irq_nxt;
    end
  end

  AST_NORMAL_OVF_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    ovf && !core_low_power |=> device_reset_r && !pc_sp_clear_r && expiry_flag_r)
    else $error("normal overflow did not reset device");

  AST_SLEEP_OVF_PCSP: assert property (@(posedge pclk) disable iff (!presetn)
    ovf && core_low_power |=> pc_sp_clear_r && !device_reset_r && expiry_flag_r)
    else $error("low power overflow wrong action");

  AST_SLEEP_OVF_KEEPS_CTRL: assert property (@(posedge pclk) disable iff (!presetn)
    ovf && core_low_power && !wr_w |=> $stable(watchdog_control_r))
    else $error("low power overflow changed control");

  AST_DISABLED_HELD: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !cfg_wdt_enable && watchdog_control_r[3:0] == 4'hA ##1 ce
    |-> count == 15'h0000 && !low_rate_clock_on_r)
    else $error("disabled timer still counting");

  AST_KEY_KEEPS_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (cfg_wdt_enable || watchdog_control_r[3:0] != 4'hA) |=> low_rate_clock_on_r)
    else $error("timer stopped with enabling key");

  AST_DISABLED_NOP: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !enabled_w && !op_stop |=> $stable(power_down_flag_r) && half_r == $past(half_r))
    else $error("disabled timer changed by kick");

  AST_KICK_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (kick_valid || !external_init_n || op_stop) |=> count == 15'h0000)
    else $error("count not cleared");

  AST_KICK_CLEARS_PWRDN: assert property (@(posedge pclk) disable iff (!presetn)
    ce && kick_valid && !op_stop |=> !power_down_flag_r)
    else $error("accepted kick left power-down flag set");

  AST_OVF_IRQ_SET: assert property (@(posedge pclk) disable iff (!presetn)
    ovf |=> irq_stat_r[`WDU_IRQ_OVF])
    else $error("overflow did not set interrupt status");

  AST_PAIR_REPEAT: assert property (@(posedge pclk) disable iff (!presetn)
    ce && enabled_w && cfg_paired_kick && half_r == WDU_HALF_FIRST && first_half_kick
    && !second_half_kick && !op_stop && external_init_n && count != 15'h0000 && !ovf
    |=> count != 15'h0000 || ovf)
    else $error("repeated half kick cleared count");

  AST_STOP_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    ce && op_stop && !ovf |=> power_down_flag_r && !expiry_flag_r ##1 count <= 15'h0001)
    else $error("stop flags wrong");

  AST_IDLE_BIT: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_w && paddr == `WDU_OFS_CTRL |=> idle_core_clock_keep_r == $past(pwdata[7]))
    else $error("idle clock bit mismatch");

  AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && penable && !pready_r |=> pready_r ##1 (!pready_r || !$past(ce)))
    else $error("apb ready timing wrong");

endmodule

// File: logic/wdu_defs.svh
`ifndef WDU_DEFS_SVH
`define WDU_DEFS_SVH

// register byte offsets
`define WDU_OFS_CTRL 8'h00
`define WDU_OFS_FLAGS 8'h04
`define WDU_OFS_IRQ_STAT 8'h08
`define WDU_OFS_IRQ_MASK 8'h0C
`define WDU_OFS_OPS 8'h10
`define WDU_OFS_COUNT 8'h14

// reset values
`define WDU_CTRL_RESET 8'h7A
`define WDU_FLAGS_RESET 2'h0
`define WDU_IRQ_RESET 2'h0

// control register fields
`define WDU_IDLE_KEEP_BIT 7
`define WDU_PSEL_HI 6
`define WDU_PSEL_LO 4
`define WDU_KEY_HI 3
`define WDU_KEY_LO 0
`define WDU_KEY_DISABLE 4'hA

// operation strobe bits
`define WDU_OP_SINGLE 0
`define WDU_OP_FIRST 1
`define WDU_OP_SECOND 2
`define WDU_OP_STOP 3

// flag and interrupt bits
`define WDU_FLAG_EXPIRY 0
`define WDU_FLAG_PWRDN 1
`define WDU_IRQ_OVF 0
`define WDU_IRQ_STOP 1

// timing
`define WDU_CORE_DIV_LAST 2'h3
`define WDU_STAGE_BASE 4'h8

`endif

// File: logic/wdu_pkg.sv
`include "wdu_defs.svh"
package wdu_pkg;

  typedef logic [7:0] wdu_ctrl_t;
  typedef logic [14:0] wdu_count_t;

  typedef enum logic [1:0] {
    WDU_HALF_NONE,
    WDU_HALF_FIRST,
    WDU_HALF_SECOND
  } wdu_half_e;

  // option and key together decide whether the timer runs
  function automatic logic wdu_enabled(input logic cfg_en, input logic [3:0] key);
    return cfg_en || (key != `WDU_KEY_DISABLE);
  endfunction

  // all stages below the selected carry stage are ones
  function automatic logic wdu_stage_full(input wdu_count_t c, input logic [2:0] s);
    logic [15:0] m;
    m = (16'h0001 << (4'(s) + `WDU_STAGE_BASE)) - 16'h0001;
    return (c & m[14:0]) == m[14:0];
  endfunction

endpackage

// File: logic/wdu_tick_gen.sv
`timescale 1ns/1ns
`include "wdu_defs.svh"
module wdu_tick_gen import wdu_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // clock sources
  input wire logic core_tick,
  input wire logic low_rate_tick,
  input wire logic sel_core,
  input wire logic core_halted,
  input wire logic run,
  // tick out
  output logic wd_tick
);

  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    div_nxt = div_r;
    tick_nxt = 1'b0;
    if (!run) begin
      div_nxt = 2'h0;
    end else if (sel_core) begin
      // core ticks are divided by four and not counted while the core clock is halted
      if (core_tick && !core_halted) begin
        if (div_r == `WDU_CORE_DIV_LAST) begin
          div_nxt = 2'h0;
          tick_nxt = 1'b1;
        end else begin
          div_nxt = div_r + 2'h1;
        end
      end
    end else begin
      tick_nxt = low_rate_tick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      tick_r <= 1'b0;
    end else if (ce) begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign wd_tick = tick_r;

  AST_HALT_NO_TICK: assert property (@(posedge pclk) disable iff (!presetn)
    ce && run && sel_core && core_halted |=> !tick_r)
    else $error("tick while core clock halted");

endmodule

// File: logic/wdu_stage_counter.sv
`timescale 1ns/1ns
`include "wdu_defs.svh"
module wdu_stage_counter import wdu_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control
  input wire logic tick,
  input wire logic clear,
  input wire logic [2:0] sel,
  // state
  output wdu_count_t count,
  output logic overflow
);

  wdu_count_t cnt_r;
  wdu_count_t cnt_nxt;
  logic ovf_r;
  logic ovf_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    ovf_nxt = 1'b0;
    if (clear) begin
      cnt_nxt = '0;
    end else if (tick) begin
      if (wdu_stage_full(cnt_r, sel)) begin
        cnt_nxt = '0;
        ovf_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 15'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      ovf_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign count = cnt_r;
  assign overflow = ovf_r && ce;

  AST_PERIOD_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tick && !clear && cnt_r == 15'((16'h0001 << (4'(sel) + 4'h8)) - 16'h0001)
    |=> ovf_r && cnt_r == 15'h0000)
    else $error("no overflow at selected stage");

endmodule

// File: tb/watchdog_timer_unit_tb_top.sv
`timescale 1ns/1ns
`include "wdu_defs.svh"
module watchdog_timer_unit_tb_top import wdu_pkg::*; ();
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } wdu_row_s;

  logic pclk, presetn, ce, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_r, q0, q1;
  logic pready_r, pslverr_r;
  logic cfg_core_div_src, cfg_wdt_enable, cfg_paired_kick;
  logic core_tick, low_rate_tick, core_halted, core_low_power, external_init_n;
  logic wake_event, deep_stop_keep_low_clock, crystal_osc, fast_wake_enable;
  logic device_reset_r, pc_sp_clear_r, idle_core_clock_keep_r;
  logic low_rate_clock_on_r, wake_on_low_speed_osc_r, irq_r, dr, pc, e;
  int err_total, n_checks, cyc;
  wdu_row_s rows [10] = '{
    '{1'h1, `WDU_OFS_IRQ_STAT, 32'h3, 32'h0, 1'h0},
    '{1'h1, `WDU_OFS_CTRL, 32'h85, 32'h0, 1'h0},
    '{1'h0, `WDU_OFS_CTRL, 32'h0, 32'h85, 1'h0},
    '{1'h1, `WDU_OFS_IRQ_MASK, 32'h3, 32'h0, 1'h0},
    '{1'h0, `WDU_OFS_IRQ_MASK, 32'h0, 32'h3, 1'h0},
    '{1'h0, `WDU_OFS_OPS, 32'h0, 32'h0, 1'h0},
    '{1'h1, `WDU_OFS_FLAGS, 32'h3, 32'h0, 1'h0},
    '{1'h0, `WDU_OFS_FLAGS, 32'h0, 32'h2, 1'h0},
    '{1'h0, 8'h18, 32'h0, 32'h0, 1'h1},
    '{1'h1, 8'h1C, 32'h1, 32'h0, 1'h1}
  };

  wdu_top i_wdu_top (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .cfg_core_div_src(cfg_core_div_src), .cfg_wdt_enable(cfg_wdt_enable),
    .cfg_paired_kick(cfg_paired_kick), .core_tick(core_tick), .low_rate_tick(low_rate_tick),
    .core_halted(core_halted), .core_low_power(core_low_power),
    .external_init_n(external_init_n), .wake_event(wake_event),
    .deep_stop_keep_low_clock(deep_stop_keep_low_clock), .crystal_osc(crystal_osc),
    .fast_wake_enable(fast_wake_enable), .device_reset_r(device_reset_r),
    .pc_sp_clear_r(pc_sp_clear_r), .idle_core_clock_keep_r(idle_core_clock_keep_r),
    .low_rate_clock_on_r(low_rate_clock_on_r),
    .wake_on_low_speed_osc_r(wake_on_low_speed_osc_r), .irq_r(irq_r)
  );

  always #4 pclk = ~pclk;

  task end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  task chkr(input string n, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
    logic ok;
    ok = (g >= lo) && (g <= hi);
    n_checks++;
    if (ok !== 1'h1) begin
      err_total++;
      $display("mismatch %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask

  // one apb transfer, held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_r !== 1'h1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    q = prdata_r;
    er = pslverr_r;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] q);
    logic er;
    apb(1'h0, a, 32'h0, q, er);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic er;
    apb(1'h1, a, d, q, er);
  endtask

  task ticks(input int n);
    @(posedge pclk);
    low_rate_tick <= 1'h1;
    repeat (n) @(posedge pclk);
    low_rate_tick <= 1'h0;
    repeat (4) @(posedge pclk);
  endtask

  // run low-rate ticks from a clear until either overflow output pulses
  task run_ovf();
    wr(`WDU_OFS_OPS, 32'h1);
    @(posedge pclk);
    low_rate_tick <= 1'h1;
    cyc = 0;
    dr = 1'h0;
    pc = 1'h0;
    while (!(dr || pc) && cyc < 1200) begin
      @(negedge pclk);
      cyc++;
      dr = (device_reset_r === 1'h1);
      pc = (pc_sp_clear_r === 1'h1);
    end
    @(posedge pclk);
    low_rate_tick <= 1'h0;
  endtask

  initial begin
    #(8 * 20000);
    err_total++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    pclk = 1'h0; presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 8'h00; pwdata = 32'h0; cfg_core_div_src = 1'h0; cfg_wdt_enable = 1'h0;
    cfg_paired_kick = 1'h0; core_tick = 1'h0; low_rate_tick = 1'h0; core_halted = 1'h0;
    core_low_power = 1'h0; external_init_n = 1'h1; wake_event = 1'h0;
    deep_stop_keep_low_clock = 1'h0; crystal_osc = 1'h0; fast_wake_enable = 1'h0;
    err_total = 0; n_checks = 0; ce = 1'h1;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    rd(`WDU_OFS_CTRL, q0); chk("ctrl_reset", 32'h7A, q0);
    rd(`WDU_OFS_FLAGS, q0); chk("flags_reset", 32'h0, q0);
    chk("clock_on_reset", 32'h0, low_rate_clock_on_r);
    ticks(10);
    rd(`WDU_OFS_COUNT, q0); chk("count_disabled", 32'h0, q0);
    wr(`WDU_OFS_OPS, 32'h8);
    wr(`WDU_OFS_OPS, 32'h1);
    rd(`WDU_OFS_FLAGS, q0); chk("kick_disabled", 32'h2, q0);
    $display("test reset_disabled done");
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, q0, e);
      if (!rows[i].w) chk("row_data", rows[i].x, q0);
      chk("row_err", {31'h0, rows[i].e}, {31'h0, e});
    end
    @(negedge pclk);
    chk("clock_on_key", 32'h1, low_rate_clock_on_r);
    chk("idle_keep", 32'h1, idle_core_clock_keep_r);
    $display("test registers done");
    run_ovf();
    chkr("period_0", 32'd256, 32'd262, cyc);
    chk("dev_reset", 32'h1, dr);
    chk("pc_sp_normal", 32'h0, pc);
    rd(`WDU_OFS_FLAGS, q0); chk("expiry_set", 32'h1, q0);
    @(negedge pclk);
    chk("irq_set", 32'h1, irq_r);
    wr(`WDU_OFS_IRQ_STAT, 32'h1);
    @(negedge pclk);
    chk("irq_clear", 32'h0, irq_r);
    $display("test overflow_normal done");
    wr(`WDU_OFS_CTRL, 32'h15);
    core_low_power <= 1'h1;
    run_ovf();
    core_low_power <= 1'h0;
    chkr("period_1", 32'd512, 32'd518, cyc);
    chk("pc_sp_low", 32'h1, pc);
    chk("dev_reset_low", 32'h0, dr);
    @(negedge pclk);
    chk("idle_keep_off", 32'h0, idle_core_clock_keep_r);
    $display("test overflow_low_power done");
    cfg_paired_kick <= 1'h1;
    wr(`WDU_OFS_CTRL, 32'h75);
    ticks(20);
    rd(`WDU_OFS_COUNT, q0); chkr("count_runs", 32'd15, 32'd25, q0);
    wr(`WDU_OFS_OPS, 32'h1);
    rd(`WDU_OFS_COUNT, q1); chk("single_in_paired", q0, q1);
    wr(`WDU_OFS_OPS, 32'h2);
    rd(`WDU_OFS_COUNT, q1); chk("first_half", 32'h0, q1);
    ticks(20);
    rd(`WDU_OFS_COUNT, q0);
    wr(`WDU_OFS_OPS, 32'h2);
    rd(`WDU_OFS_COUNT, q1); chk("first_again", q0, q1);
    wr(`WDU_OFS_OPS, 32'h4);
    rd(`WDU_OFS_COUNT, q1); chk("second_half", 32'h0, q1);
    $display("test paired_kick done");
    ticks(20);
    wr(`WDU_OFS_OPS, 32'h8);
    rd(`WDU_OFS_COUNT, q0); chk("stop_clears", 32'h0, q0);
    rd(`WDU_OFS_FLAGS, q0); chk("stop_flags", 32'h2, q0);
    wr(`WDU_OFS_OPS, 32'h2);
    rd(`WDU_OFS_FLAGS, q0); chk("kick_pwrdn", 32'h0, q0);
    cfg_paired_kick <= 1'h0;
    ticks(20);
    @(posedge pclk);
    external_init_n <= 1'h0;
    @(posedge pclk);
    external_init_n <= 1'h1;
    rd(`WDU_OFS_COUNT, q0); chk("init_pin", 32'h0, q0);
    $display("test clear_sources done");
    cfg_wdt_enable <= 1'h1;
    wr(`WDU_OFS_CTRL, 32'h7A);
    ticks(10);
    rd(`WDU_OFS_COUNT, q0); chk("count_cfg_en", 32'd10, q0);
    @(posedge pclk);
    ce <= 1'h0;
    low_rate_tick <= 1'h1;
    repeat (10) @(posedge pclk);
    ce <= 1'h1;
    low_rate_tick <= 1'h0;
    rd(`WDU_OFS_COUNT, q1); chk("ce_freeze", q0, q1);
    cfg_wdt_enable <= 1'h0;
    ticks(4);
    chk("clock_off_key", 32'h0, low_rate_clock_on_r);
    rd(`WDU_OFS_COUNT, q0); chk("count_off_key", 32'h0, q0);
    wr(`WDU_OFS_CTRL, 32'h75);
    $display("test option_and_enable done");
    cfg_core_div_src <= 1'h1;
    wr(`WDU_OFS_OPS, 32'h1);
    @(posedge pclk);
    core_tick <= 1'h1;
    low_rate_tick <= 1'h1;
    repeat (40) @(posedge pclk);
    core_halted <= 1'h1;
    repeat (4) @(posedge pclk);
    rd(`WDU_OFS_COUNT, q0); chkr("core_div4", 32'd9, 32'd12, q0);
    repeat (40) @(posedge pclk);
    rd(`WDU_OFS_COUNT, q1); chk("core_halted", q0, q1);
    core_tick <= 1'h0;
    core_halted <= 1'h0;
    low_rate_tick <= 1'h0;
    $display("test core_source done");
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      crystal_osc <= 1'h1;
      deep_stop_keep_low_clock <= 1'h1;
      fast_wake_enable <= i[0];
      wake_event <= 1'h1;
      @(posedge pclk);
      wake_event <= 1'h0;
      repeat (2) @(negedge pclk);
      chk("wake_osc", {31'h0, i[0]}, {31'h0, wake_on_low_speed_osc_r});
    end
    $display("test wake done");
    end_sim();
  end
endmodule
